// ===== ugr_defines.svh
// Constants for the user glyph memory block: widths, field positions, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef UGR_DEFINES_SVH
`define UGR_DEFINES_SVH

// ****************************************************************
// Glyph memory geometry
// ****************************************************************
`define UGR_ADDR_W 6
`define UGR_ROW_W 5
`define UGR_CODE_W 8
`define UGR_ROW_LSB 0
`define UGR_ROW_MSB 2
`define UGR_SLOT8_LSB 3
`define UGR_SLOT8_MSB 5
`define UGR_SLOT10_LSB 4
`define UGR_SLOT10_MSB 5
`define UGR_CODE_SLOT8_MSB 2
`define UGR_CODE_SLOT10_LSB 1
`define UGR_CODE_SLOT10_MSB 2
`define UGR_CODE_SEL_LSB 4
`define UGR_CODE_SEL_MSB 7
`define UGR_CURSOR_ROW8 3'h7
`define UGR_CURSOR_ROW10 4'ha
`define UGR_ROWS10 4'ha
`define UGR_ADDR_RST 6'h00
`define UGR_ROW_RST 5'h00

`endif

// ===== ugr_pkg.sv
// Types shared by the user glyph memory block, its host model and its bench.
// Assumes ugr_defines.svh is on the include path.
`default_nettype none
`include "ugr_defines.svh"

package ugr_pkg;

    // Host access request carried as one bundle.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] data;
    } ugr_host_s;

    // Display scan request carried as one bundle.
    typedef struct packed {
        logic valid;
        logic [`UGR_CODE_W-1:0] code;
        logic [3:0] row;
        logic [`UGR_ROW_W-1:0] cursor;
    } ugr_scan_s;

    // Host access sequencing.
    typedef enum logic [1:0] {
        UGR_IDLE = 2'b01,
        UGR_READ = 2'b10
    } ugr_state_e;

endpackage
`default_nettype wire

// ===== ugr_mem.sv
// Small three-port glyph row memory: one write port, two registered read ports.
// Assumes a single clock; read data appear one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
`include "ugr_defines.svh"

module ugr_mem #(
    parameter int ADDR_W = `UGR_ADDR_W,
    parameter int DATA_W = `UGR_ROW_W
) (
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [ADDR_W-1:0] waddr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [ADDR_W-1:0] raddr_a,
    output logic [DATA_W-1:0] rdata_a,
    input wire logic [ADDR_W-1:0] raddr_b,
    output logic [DATA_W-1:0] rdata_b
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // Contents are not reset; software loads patterns before use.
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end

endmodule
`default_nettype wire

// ===== ugr_glyph.sv
// Writable glyph memory with host access and display row lookup.
// Assumes the host issues one access at a time and that scan requests come from the timing logic.
`timescale 1ns/1ps
`default_nettype none
`include "ugr_defines.svh"

module ugr_glyph #(
    parameter int ADDR_W = `UGR_ADDR_W
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic font_10,
    input wire logic addr_load,
    input wire logic [ADDR_W-1:0] addr_value,
    input wire logic addr_inc,
    input wire ugr_pkg::ugr_host_s host_req,
    input wire ugr_pkg::ugr_scan_s scan_req,
    output logic [ADDR_W-1:0] address_counter,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    output logic [4:0] dots,
    output logic dots_valid,
    output logic dots_user
);

    // ****************************************************************
    // Checks and decode helpers
    // ****************************************************************
    // Slot and row fields fill exactly six address bits, so no other width can be served.
    if (ADDR_W != `UGR_ADDR_W) begin : g_addr_w_check
        $error("ugr_glyph: ADDR_W must be 6");
    end

    // True when the character code refers to the writable memory.
    function automatic logic is_user_code(input logic [7:0] code);
        is_user_code = (code[`UGR_CODE_SEL_MSB:`UGR_CODE_SEL_LSB] == 4'h0);
    endfunction

    // Builds the memory address of one glyph row for either font.
    function automatic logic [ADDR_W-1:0] glyph_addr(input logic f10, input logic [7:0] code,
                                                     input logic [3:0] row);
        if (f10) begin
            glyph_addr = {code[`UGR_CODE_SLOT10_MSB:`UGR_CODE_SLOT10_LSB], row};
        end else begin
            glyph_addr = {code[`UGR_CODE_SLOT8_MSB:0], row[2:0]};
        end
    endfunction

    // True when the row is the cursor row of the active font.
    function automatic logic is_cursor_row(input logic f10, input logic [3:0] row);
        if (f10) begin
            is_cursor_row = (row == `UGR_CURSOR_ROW10);
        end else begin
            is_cursor_row = (row[2:0] == `UGR_CURSOR_ROW8);
        end
    endfunction

    // ****************************************************************
    // Host side: address counter and accesses
    // ****************************************************************
    ugr_pkg::ugr_state_e state, next_state;
    logic [ADDR_W-1:0] next_address_counter;
    logic [7:0] next_host_rdata;
    logic next_host_rvalid;
    logic mem_we;
    logic [4:0] mem_rdata_a;
    logic [4:0] mem_rdata_b;

    // A write lands at once; a read waits one cycle for the registered memory port.
    always_comb begin
        next_state = state;
        next_address_counter = address_counter;
        next_host_rdata = host_rdata;
        next_host_rvalid = 1'b0;
        mem_we = 1'b0;
        unique case (state)
            ugr_pkg::UGR_IDLE: begin
                if (addr_load) begin
                    next_address_counter = addr_value;
                end else if (host_req.wr) begin
                    mem_we = 1'b1;
                    next_address_counter = addr_inc ? address_counter + 6'h01
                                                    : address_counter - 6'h01;
                end else if (host_req.rd) begin
                    next_state = ugr_pkg::UGR_READ;
                end
            end
            ugr_pkg::UGR_READ: begin
                next_host_rdata = {3'h0, mem_rdata_a};
                next_host_rvalid = 1'b1;
                next_address_counter = addr_inc ? address_counter + 6'h01
                                                : address_counter - 6'h01;
                next_state = ugr_pkg::UGR_IDLE;
            end
            default: begin
                next_state = ugr_pkg::UGR_IDLE;
            end
        endcase
    end

    // Host state registers.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ugr_pkg::UGR_IDLE;
            address_counter <= `UGR_ADDR_RST;
            host_rdata <= 8'h00;
            host_rvalid <= 1'b0;
        end else begin
            state <= next_state;
            address_counter <= next_address_counter;
            host_rdata <= next_host_rdata;
            host_rvalid <= next_host_rvalid;
        end
    end

    // ****************************************************************
    // Glyph memory
    // ****************************************************************
    logic [ADDR_W-1:0] scan_addr;
    assign scan_addr = glyph_addr(font_10, scan_req.code, scan_req.row);

    // Only five dot bits are stored, so upper data bits vanish on write.
    ugr_mem #(
        .ADDR_W(ADDR_W),
        .DATA_W(`UGR_ROW_W)
    ) u_mem (
        .sys_clk(sys_clk),
        .we(mem_we),
        .waddr(address_counter),
        .wdata(host_req.data[4:0]),
        .raddr_a(address_counter),
        .rdata_a(mem_rdata_a),
        .raddr_b(scan_addr),
        .rdata_b(mem_rdata_b)
    );

    // ****************************************************************
    // Display scan pipeline
    // ****************************************************************
    logic s1_valid, next_s1_valid;
    logic s1_user, next_s1_user;
    logic s1_cursor_row, next_s1_cursor_row;
    logic [4:0] s1_cursor, next_s1_cursor;
    logic [4:0] next_dots;
    logic next_dots_valid;
    logic next_dots_user;

    // Stage one captures the request beside the memory read; stage two merges the cursor.
    always_comb begin
        next_s1_valid = scan_req.valid;
        next_s1_user = is_user_code(scan_req.code);
        next_s1_cursor_row = is_cursor_row(font_10, scan_req.row);
        next_s1_cursor = scan_req.cursor;
        next_dots_valid = s1_valid;
        next_dots_user = s1_valid & s1_user;
        next_dots = 5'h00;
        if (s1_valid && s1_user) begin
            // Bit 4 is the leftmost dot; a one lights it.
            if (s1_cursor_row) begin
                next_dots = mem_rdata_b | s1_cursor;
            end else begin
                next_dots = mem_rdata_b;
            end
        end
    end

    // Scan registers; the panel sees dots only from flip-flops.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s1_valid <= 1'b0;
            s1_user <= 1'b0;
            s1_cursor_row <= 1'b0;
            s1_cursor <= `UGR_ROW_RST;
            dots <= `UGR_ROW_RST;
            dots_valid <= 1'b0;
            dots_user <= 1'b0;
        end else begin
            s1_valid <= next_s1_valid;
            s1_user <= next_s1_user;
            s1_cursor_row <= next_s1_cursor_row;
            s1_cursor <= next_s1_cursor;
            dots <= next_dots;
            dots_valid <= next_dots_valid;
            dots_user <= next_dots_user;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_user_req;
        scan_req.valid && is_user_code(scan_req.code);
    endsequence

    // User request on the cursor row of the active font.
    sequence s_user_cursor;
        s_user_req ##0 is_cursor_row(font_10, scan_req.row);
    endsequence

    // User request on any other row.
    sequence s_user_plain;
        s_user_req ##0 !is_cursor_row(font_10, scan_req.row);
    endsequence

    // Host read taken in the idle state.
    sequence s_rd_take;
        state == ugr_pkg::UGR_IDLE && !addr_load && !host_req.wr && host_req.rd;
    endsequence

    property p_user_sel;
        @(posedge sys_clk) disable iff (!nrst)
        s_user_req |-> ##2 dots_user;
    endproperty
    a_user_sel: assert property (p_user_sel) else $error("user glyph not selected");

    property p_fixed_dark;
        @(posedge sys_clk) disable iff (!nrst)
        (scan_req.valid && !is_user_code(scan_req.code)) |-> ##2 (!dots_user && dots == 5'h00);
    endproperty
    a_fixed_dark: assert property (p_fixed_dark) else $error("fixed code took user path");

    property p_cursor_or;
        @(posedge sys_clk) disable iff (!nrst)
        s_user_cursor |-> ##2 ((dots & $past(scan_req.cursor, 2)) == $past(scan_req.cursor, 2));
    endproperty
    a_cursor_or: assert property (p_cursor_or) else $error("cursor dots missing");

    property p_no_cursor_off_row;
        @(posedge sys_clk) disable iff (!nrst)
        s_user_plain |-> ##2 (dots == $past(mem_rdata_b));
    endproperty
    a_no_cursor_off_row: assert property (p_no_cursor_off_row) else $error("cursor on wrong row");

    property p_wr_step;
        @(posedge sys_clk) disable iff (!nrst)
        (state == ugr_pkg::UGR_IDLE && !addr_load && host_req.wr && addr_inc)
            |=> (address_counter == $past(address_counter) + 6'h01);
    endproperty
    a_wr_step: assert property (p_wr_step) else $error("counter did not step up");

    property p_rd_step;
        @(posedge sys_clk) disable iff (!nrst)
        (state == ugr_pkg::UGR_IDLE && !addr_load && !host_req.wr && host_req.rd && !addr_inc)
            ##1 !addr_inc |=> (address_counter == $past(address_counter, 2) - 6'h01) && host_rvalid;
    endproperty
    a_rd_step: assert property (p_rd_step) else $error("read did not step down");

    property p_rdata_high;
        @(posedge sys_clk) disable iff (!nrst)
        host_rvalid |-> (host_rdata[7:5] == 3'h0);
    endproperty
    a_rdata_high: assert property (p_rdata_high) else $error("upper data bits kept");

    property p_bit3_ignored;
        @(posedge sys_clk) disable iff (!nrst)
        glyph_addr(font_10, scan_req.code, scan_req.row)
            == glyph_addr(font_10, scan_req.code ^ 8'h08, scan_req.row);
    endproperty
    a_bit3_ignored: assert property (p_bit3_ignored) else $error("code bit 3 changed address");

    property p_slot_map;
        @(posedge sys_clk) disable iff (!nrst)
        !font_10 |-> (scan_addr[`UGR_SLOT8_MSB:`UGR_SLOT8_LSB] == scan_req.code[2:0]
                      && scan_addr[2:0] == scan_req.row[2:0]);
    endproperty
    a_slot_map: assert property (p_slot_map) else $error("glyph address map wrong");

    property p_stored_show;
        @(posedge sys_clk) disable iff (!nrst)
        s_user_cursor |-> ##2 ((dots & $past(mem_rdata_b)) == $past(mem_rdata_b));
    endproperty
    a_stored_show: assert property (p_stored_show) else $error("stored cursor row dots lost");

    property p_idle_dark;
        @(posedge sys_clk) disable iff (!nrst)
        !scan_req.valid |-> ##2 (!dots_valid && !dots_user && dots == 5'h00);
    endproperty
    a_idle_dark: assert property (p_idle_dark) else $error("dots shown without a request");

    property p_rvalid_pulse;
        @(posedge sys_clk) disable iff (!nrst)
        s_rd_take |-> ##2 host_rvalid ##1 !host_rvalid;
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer not a single pulse");

    property p_load;
        @(posedge sys_clk) disable iff (!nrst)
        (state == ugr_pkg::UGR_IDLE && addr_load) |=> (address_counter == $past(addr_value));
    endproperty
    a_load: assert property (p_load) else $error("counter load lost");

    property p_slot_map10;
        @(posedge sys_clk) disable iff (!nrst)
        font_10 |-> (scan_addr[`UGR_SLOT10_MSB:`UGR_SLOT10_LSB] == scan_req.code[2:1]
                     && scan_addr[3:0] == scan_req.row);
    endproperty
    a_slot_map10: assert property (p_slot_map10) else $error("tall glyph address map wrong");

endmodule
`default_nettype wire

// ===== ugr_host_model.sv
// Host processor model that loads the address counter and moves glyph rows.
// Assumes the glyph block samples on the rising edge; requests change at falling edges.
`timescale 1ns/1ps
`default_nettype none

module ugr_host_model (
    input wire logic sys_clk,
    input wire logic host_rvalid,
    input wire logic [7:0] host_rdata,
    output logic addr_load,
    output logic [5:0] addr_value,
    output logic addr_inc,
    output var ugr_pkg::ugr_host_s host_req
);
    // Idle values; data lines carry a pattern, never a stale copy.
    initial begin
        addr_load = 1'b0;
        addr_value = 6'h15;
        addr_inc = 1'b1;
        host_req = '{wr: 1'b0, rd: 1'b0, data: 8'h5a};
    end

    // Load the counter and set the step direction for later accesses.
    task automatic load(input logic [5:0] a, input logic up);
        @(negedge sys_clk);
        addr_load = 1'b1;
        addr_value = a;
        addr_inc = up;
        @(negedge sys_clk);
        addr_load = 1'b0;
        addr_value = ~a;
    endtask

    // One-cycle write pulse; the caller chooses the row bits, zero cursor rows included.
    task automatic write(input logic [7:0] d);
        @(negedge sys_clk);
        host_req.wr = 1'b1;
        host_req.data = d;
        @(negedge sys_clk);
        host_req.wr = 1'b0;
        host_req.data = ~d;
    endtask

    // Read pulse, then a bounded wait for the answer; n counts the extra cycles.
    task automatic read(output logic [7:0] d, output int n);
        @(negedge sys_clk);
        host_req.rd = 1'b1;
        @(negedge sys_clk);
        host_req.rd = 1'b0;
        n = 0;
        while (host_rvalid !== 1'b1 && n < 8) begin
            @(negedge sys_clk);
            n++;
        end
        d = host_rdata;
    endtask
endmodule

`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the user glyph memory block.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    typedef struct packed {
        logic [7:0] code;
        logic [3:0] row;
        logic [4:0] cur;
        logic f10;
        logic [4:0] dots;
        logic user;
    } ugr_tb_row_s;

    logic sys_clk, nrst, font_10, addr_load, addr_inc, host_rvalid, dots_valid, dots_user;
    logic [5:0] addr_value, address_counter;
    logic [7:0] host_rdata, rd;
    logic [4:0] dots;
    ugr_pkg::ugr_host_s host_req;
    ugr_pkg::ugr_scan_s scan_req;
    int error_cnt, checked, n;

    // Scan cases: code, row, cursor, font, expected dots, expected user flag.
    localparam ugr_tb_row_s ROWS [15] = '{
        '{8'h00, 4'h0, 5'h00, 1'b0, 5'h0a, 1'b1}, '{8'h08, 4'h0, 5'h00, 1'b0, 5'h0a, 1'b1},
        '{8'h03, 4'h5, 5'h00, 1'b0, 5'h17, 1'b1}, '{8'h07, 4'h2, 5'h00, 1'b0, 5'h10, 1'b1},
        '{8'h02, 4'h7, 5'h1f, 1'b0, 5'h1f, 1'b1}, '{8'h02, 4'h7, 5'h00, 1'b0, 5'h00, 1'b1},
        '{8'h05, 4'h7, 5'h04, 1'b0, 5'h15, 1'b1}, '{8'h05, 4'h7, 5'h00, 1'b0, 5'h11, 1'b1},
        '{8'h10, 4'h0, 5'h00, 1'b0, 5'h00, 1'b0}, '{8'h80, 4'h1, 5'h00, 1'b0, 5'h00, 1'b0},
        '{8'h0e, 4'h6, 5'h00, 1'b0, 5'h1c, 1'b1}, '{8'h02, 4'h3, 5'h00, 1'b1, 5'h19, 1'b1},
        '{8'h01, 4'h1, 5'h1f, 1'b0, 5'h03, 1'b1}, '{8'h02, 4'ha, 5'h01, 1'b1, 5'h11, 1'b1},
        '{8'h00, 4'h7, 5'h1f, 1'b1, 5'h00, 1'b1}};

    ugr_glyph u_ugr_glyph (.sys_clk(sys_clk), .nrst(nrst), .font_10(font_10), .addr_load(addr_load),
        .addr_value(addr_value), .addr_inc(addr_inc), .host_req(host_req), .scan_req(scan_req),
        .address_counter(address_counter), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
        .dots(dots), .dots_valid(dots_valid), .dots_user(dots_user));

    ugr_host_model u_host (.sys_clk(sys_clk), .host_rvalid(host_rvalid), .host_rdata(host_rdata),
        .addr_load(addr_load), .addr_value(addr_value), .addr_inc(addr_inc), .host_req(host_req));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Row content written at address a; glyph 5 breaks the zero cursor row on purpose.
    function automatic logic [7:0] wdata(input logic [5:0] a);
        if (a == 6'h2f) begin
            return 8'h11;
        end
        if (a[2:0] == 3'h7) begin
            return 8'he0;
        end
        return {3'b111, a[4:0] ^ 5'h0a};
    endfunction

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One scan request, checked when the two-cycle pipeline delivers it.
    task automatic scan(input ugr_tb_row_s r);
        @(negedge sys_clk);
        font_10 = r.f10;
        scan_req = '{valid: 1'b1, code: r.code, row: r.row, cursor: r.cur};
        @(negedge sys_clk);
        scan_req.valid = 1'b0;
        scan_req.code = ~r.code;
        // The answer stands for one cycle only, so look at the very next falling edge.
        @(negedge sys_clk);
        cmp(8'(dots_valid), 8'h01, "dots valid");
        cmp(8'(dots_user), 8'(r.user), "user flag");
        cmp(8'(dots), 8'(r.dots), "dots");
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and tests
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        repeat (3000) @(posedge sys_clk);
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        nrst = 1'b0;
        font_10 = 1'b0;
        scan_req = '0;
        repeat (16) @(negedge sys_clk);
        nrst = 1'b1;
        cmp(8'(address_counter), 8'h00, "reset counter");
        cmp(8'(dots), 8'h00, "reset dots");
        // Fill all 64 rows upward; the counter must wrap back to zero.
        u_host.load(6'h00, 1'b1);
        for (int a = 0; a < 64; a++) begin
            u_host.write(wdata(6'(a)));
        end
        @(negedge sys_clk);
        cmp(8'(address_counter), 8'h00, "counter after fill");
        foreach (ROWS[i]) begin
            scan(ROWS[i]);
        end
        // Rewrite a live pattern and see it through the aliased code.
        u_host.load(6'h00, 1'b1);
        u_host.write(8'hf1);
        scan('{8'h08, 4'h0, 5'h00, 1'b0, 5'h11, 1'b1});
        // Read back downward: upper bits dropped, counter steps down.
        u_host.load(6'h1d, 1'b0);
        u_host.read(rd, n);
        cmp(rd, 8'h17, "read data");
        cmp(8'(n), 8'h01, "read latency");
        cmp(8'(address_counter), 8'h1c, "counter down");
        @(negedge sys_clk);
        cmp(8'(host_rvalid), 8'h00, "rvalid pulse");
        cmp(host_rdata, 8'h17, "read data held");
        u_host.read(rd, n);
        cmp(rd, 8'h16, "read data");
        cmp(8'(n), 8'h01, "read latency");
        cmp(8'(address_counter), 8'h1b, "counter down");
        // A reset in mid-run clears the counter and the outputs.
        @(negedge sys_clk);
        nrst = 1'b0;
        @(negedge sys_clk);
        cmp(8'(address_counter), 8'h00, "reset counter");
        cmp(8'(host_rvalid), 8'h00, "reset rvalid");
        nrst = 1'b1;
        // Two quiet edges after release; the glyph rows must survive the reset.
        repeat (2) @(negedge sys_clk);
        cmp(8'(dots_valid), 8'h00, "reset dots valid");
        cmp(8'(address_counter), 8'h00, "counter after release");
        scan('{8'h00, 4'h0, 5'h00, 1'b0, 5'h11, 1'b1});
        summarize();
    end
endmodule

`default_nettype wire
